/* File: src/tpmu_pkg.sv */
// Shared constants and types for the table pointer move unit.
package tpmu_pkg;
   localparam int          WORD_W      = 16;
   localparam int          LEN_W       = 8;
   localparam int          MEM_AW      = 10;
   localparam int          MEM_DEPTH   = 1024;
   localparam logic [15:0] PTR_ZERO    = 16'h0000;
   localparam logic [15:0] PTR_STEP    = 16'h0001;
   localparam logic [15:0] FIRST_ENTRY = 16'h0001;
   localparam logic [7:0]  LEN_PAD     = 8'h00;

   typedef enum logic [1:0] {
      REMOVE_FROM_BOTTOM_OP,
      SOURCE_TO_TABLE_OP,
      REMOVE_FROM_TABLE_OP
   } tpmu_op_e;
endpackage : tpmu_pkg

/* File: src/tpmu_if.sv */
// Link between the instruction sequencer end and the table move unit end.
`timescale 1ns/1ps
interface tpmu_if;
   import tpmu_pkg::*;
   logic                op_start;
   tpmu_op_e            op_kind;
   logic [LEN_W-1:0]    tbl_len;
   logic [WORD_W-1:0]   tbl_base;
   logic [WORD_W-1:0]   operand_addr;
   logic                scan_end;
   logic                busy;
   logic                done;
   logic                table_status_flag;
   logic                mem_en;
   logic                mem_we;
   logic [WORD_W-1:0]   mem_addr;
   logic [WORD_W-1:0]   mem_wdata;
   logic [WORD_W-1:0]   mem_rdata;

   modport dev (
      input  op_start, op_kind, tbl_len, tbl_base, operand_addr, scan_end, mem_rdata,
      output busy, done, table_status_flag, mem_en, mem_we, mem_addr, mem_wdata
   );
   modport seq (
      output op_start, op_kind, tbl_len, tbl_base, operand_addr, scan_end, mem_rdata,
      input  busy, done, table_status_flag, mem_en, mem_we, mem_addr, mem_wdata
   );
endinterface : tpmu_if

/* File: src/tpmu_engine.sv */
// Table move engine: executes the three table operations on word memory.
`timescale 1ns/1ps
module tpmu_engine
   import tpmu_pkg::*;
(
   input  wire logic  clock,
   input  wire logic  srst,
   tpmu_if.dev        lnk,
   output logic       flag_out,
   output logic       busy_out
);

   // ----------------------------------------------------------------
   // State and captured parameters
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      S_IDLE, S_PTR_WAIT, S_PTR, S_RD_WAIT, S_WR, S_NEXT, S_FIN
   } tpmu_state_e;

   tpmu_state_e         st_q;
   tpmu_op_e            op_q;
   logic [WORD_W-1:0]   len_q;
   logic [WORD_W-1:0]   base_q;
   logic [WORD_W-1:0]   opnd_q;
   logic [WORD_W-1:0]   cnt_q;
   logic [WORD_W-1:0]   np_q;
   logic [WORD_W-1:0]   k_q;
   logic                flag_pend_q;
   logic                ran_q;
   logic                flag_q;
   logic                done_q;
   logic                busy_q;
   logic                mem_en_q;
   logic                mem_we_q;
   logic [WORD_W-1:0]   mem_addr_q;
   logic [WORD_W-1:0]   mem_wdata_q;

   logic                start_ok;
   logic [WORD_W-1:0]   ptr;
   logic                skip;
   logic [WORD_W-1:0]   src_d;
   logic [WORD_W-1:0]   dst_d;
   logic [WORD_W-1:0]   np_d;
   logic                flag_d;
   logic [WORD_W-1:0]   dst_q;
   logic                shift_more;
   logic                fin_now;
   logic                fin_flag;

   assign start_ok   = lnk.op_start && st_q == S_IDLE && !ran_q;
   assign ptr        = lnk.mem_rdata;
   assign shift_more = op_q == REMOVE_FROM_TABLE_OP && k_q < cnt_q;
   assign fin_now    = (st_q == S_PTR && skip) || st_q == S_FIN;
   assign fin_flag   = (st_q == S_PTR) ? flag_d : flag_pend_q;

   // ----------------------------------------------------------------
   // Decision on the pointer or counter word just read
   // ----------------------------------------------------------------
   always_comb begin
      skip   = 1'b0;
      src_d  = opnd_q;
      dst_d  = opnd_q;
      np_d   = ptr;
      flag_d = 1'b0;
      unique case (op_q)
         REMOVE_FROM_BOTTOM_OP: begin
            skip   = ptr == PTR_ZERO;
            src_d  = base_q + ptr;
            np_d   = ptr - PTR_STEP;
            flag_d = skip || np_d == PTR_ZERO;
         end
         SOURCE_TO_TABLE_OP: begin
            skip = ptr > len_q;
            if (ptr == PTR_ZERO || ptr == len_q) begin
               np_d = FIRST_ENTRY;
            end else begin
               np_d = ptr + PTR_STEP;
            end
            dst_d  = base_q + np_d;
            flag_d = !skip && np_d == len_q;
         end
         REMOVE_FROM_TABLE_OP: begin
            skip   = ptr == PTR_ZERO || ptr > len_q;
            src_d  = base_q + FIRST_ENTRY;
            np_d   = ptr - PTR_STEP;
            flag_d = skip || np_d == PTR_ZERO;
         end
         default: begin
            skip   = 1'b1;
            flag_d = 1'b0;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Sequencing and memory access
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (srst) begin
         st_q        <= S_IDLE;
         op_q        <= REMOVE_FROM_BOTTOM_OP;
         len_q       <= PTR_ZERO;
         base_q      <= PTR_ZERO;
         opnd_q      <= PTR_ZERO;
         cnt_q       <= PTR_ZERO;
         np_q        <= PTR_ZERO;
         k_q         <= PTR_ZERO;
         dst_q       <= PTR_ZERO;
         flag_pend_q <= 1'b0;
         mem_en_q    <= 1'b0;
         mem_we_q    <= 1'b0;
         mem_addr_q  <= PTR_ZERO;
         mem_wdata_q <= PTR_ZERO;
      end else begin
         unique case (st_q)
            S_IDLE: begin
               mem_en_q <= 1'b0;
               if (start_ok) begin
                  op_q       <= lnk.op_kind;
                  len_q      <= {LEN_PAD, lnk.tbl_len};
                  base_q     <= lnk.tbl_base;
                  opnd_q     <= lnk.operand_addr;
                  mem_en_q   <= 1'b1;
                  mem_we_q   <= 1'b0;
                  mem_addr_q <= lnk.tbl_base;
                  st_q       <= S_PTR_WAIT;
               end
            end
            S_PTR_WAIT: begin
               mem_en_q <= 1'b0;
               st_q     <= S_PTR;
            end
            S_PTR: begin
               cnt_q       <= ptr;
               np_q        <= np_d;
               flag_pend_q <= flag_d;
               k_q         <= FIRST_ENTRY;
               dst_q       <= dst_d;
               if (skip) begin
                  st_q <= S_IDLE;
               end else begin
                  mem_en_q   <= 1'b1;
                  mem_we_q   <= 1'b0;
                  mem_addr_q <= src_d;
                  st_q       <= S_RD_WAIT;
               end
            end
            S_RD_WAIT: begin
               mem_en_q <= 1'b0;
               st_q     <= S_WR;
            end
            S_WR: begin
               mem_en_q    <= 1'b1;
               mem_we_q    <= 1'b1;
               mem_addr_q  <= dst_q;
               mem_wdata_q <= lnk.mem_rdata;
               st_q        <= S_NEXT;
            end
            S_NEXT: begin
               mem_en_q <= 1'b1;
               if (shift_more) begin
                  mem_we_q   <= 1'b0;
                  mem_addr_q <= base_q + k_q + PTR_STEP;
                  dst_q      <= base_q + k_q;
                  k_q        <= k_q + PTR_STEP;
                  st_q       <= S_RD_WAIT;
               end else begin
                  mem_we_q    <= 1'b1;
                  mem_addr_q  <= base_q;
                  mem_wdata_q <= np_q;
                  st_q        <= S_FIN;
               end
            end
            S_FIN: begin
               mem_en_q <= 1'b0;
               mem_we_q <= 1'b0;
               st_q     <= S_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Once-per-scan guard
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (srst) begin
         ran_q <= 1'b0;
      end else if (start_ok) begin
         ran_q <= 1'b1;
      end else if (lnk.scan_end) begin
         ran_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Shared status flag, completion and busy
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (srst) begin
         flag_q <= 1'b0;
      end else if (fin_now) begin
         flag_q <= fin_flag;
      end else if (lnk.scan_end) begin
         flag_q <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         done_q <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         done_q <= fin_now;
         if (start_ok) begin
            busy_q <= 1'b1;
         end else if (fin_now) begin
            busy_q <= 1'b0;
         end
      end
   end

   assign lnk.busy              = busy_q;
   assign lnk.done              = done_q;
   assign lnk.table_status_flag = flag_q;
   assign lnk.mem_en            = mem_en_q;
   assign lnk.mem_we            = mem_we_q;
   assign lnk.mem_addr          = mem_addr_q;
   assign lnk.mem_wdata         = mem_wdata_q;
   assign flag_out              = flag_q;
   assign busy_out              = busy_q;

endmodule : tpmu_engine

/* File: src/tpmu_sequencer.sv */
// Sequencer end: scan control, parameter loads and the word data memory.
`timescale 1ns/1ps
module tpmu_sequencer
   import tpmu_pkg::*;
(
   input  wire logic                 clock,
   input  wire logic                 srst,
   tpmu_if.seq                       lnk,
   input  wire logic                 enabling_input_contact,
   input  wire logic                 rising_one_shot,
   input  wire tpmu_op_e             op_sel,
   input  wire logic [LEN_W-1:0]     table_len,
   input  wire logic [WORD_W-1:0]    table_base,
   input  wire logic [WORD_W-1:0]    operand_addr,
   input  wire logic                 scan_end_req,
   input  wire logic                 user_mem_we,
   input  wire logic [WORD_W-1:0]    user_mem_addr,
   input  wire logic [WORD_W-1:0]    user_mem_wdata,
   output logic [WORD_W-1:0]         user_mem_rdata,
   output logic                      seq_busy,
   output logic                      table_flag,
   output logic                      op_done
);

   // ----------------------------------------------------------------
   // Issue sequence
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {H_IDLE, H_LOAD_ADDR, H_ISSUE, H_WAIT} tpmu_hstate_e;

   tpmu_hstate_e        hs_q;
   logic [LEN_W-1:0]    stack_q;
   logic [WORD_W-1:0]   acc_q;
   logic [WORD_W-1:0]   opnd_q;
   tpmu_op_e            op_q;
   logic                start_q;
   logic                issued_q;
   logic                en_d_q;
   logic                rise_q;
   logic                scan_end_q;
   logic                busy_q;
   logic                flag_q;
   logic                done_q;
   logic [WORD_W-1:0]   rdata_q;
   logic [WORD_W-1:0]   urdata_q;
   logic [WORD_W-1:0]   mem [MEM_DEPTH];
   logic                want;

   assign want = rising_one_shot ? rise_q : enabling_input_contact;

   always_ff @(posedge clock) begin
      if (srst) begin
         hs_q    <= H_IDLE;
         stack_q <= LEN_PAD;
         acc_q   <= PTR_ZERO;
         opnd_q  <= PTR_ZERO;
         op_q    <= REMOVE_FROM_BOTTOM_OP;
         start_q <= 1'b0;
      end else begin
         unique case (hs_q)
            H_IDLE: begin
               if (want && !issued_q && !scan_end_q) begin
                  stack_q <= table_len;
                  op_q    <= op_sel;
                  opnd_q  <= operand_addr;
                  hs_q    <= H_LOAD_ADDR;
               end
            end
            H_LOAD_ADDR: begin
               acc_q <= table_base;
               hs_q  <= H_ISSUE;
            end
            H_ISSUE: begin
               start_q <= 1'b1;
               hs_q    <= H_WAIT;
            end
            H_WAIT: begin
               start_q <= 1'b0;
               if (lnk.done) begin
                  hs_q <= H_IDLE;
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Scan bookkeeping and one-shot
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (srst) begin
         issued_q   <= 1'b0;
         en_d_q     <= 1'b0;
         rise_q     <= 1'b0;
         scan_end_q <= 1'b0;
      end else begin
         scan_end_q <= scan_end_req;
         en_d_q     <= enabling_input_contact;
         if (hs_q == H_ISSUE) begin
            issued_q <= 1'b1;
         end else if (scan_end_q) begin
            issued_q <= 1'b0;
         end
         if (enabling_input_contact && !en_d_q) begin
            rise_q <= 1'b1;
         end else if (hs_q == H_ISSUE) begin
            rise_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Word data memory
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (lnk.mem_en && lnk.mem_we) begin
         mem[lnk.mem_addr[MEM_AW-1:0]] <= lnk.mem_wdata;
      end else if (user_mem_we && !busy_q) begin
         mem[user_mem_addr[MEM_AW-1:0]] <= user_mem_wdata;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         rdata_q  <= PTR_ZERO;
         urdata_q <= PTR_ZERO;
      end else begin
         if (lnk.mem_en && !lnk.mem_we) begin
            rdata_q <= mem[lnk.mem_addr[MEM_AW-1:0]];
         end
         urdata_q <= mem[user_mem_addr[MEM_AW-1:0]];
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         busy_q <= 1'b0;
         flag_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         busy_q <= hs_q != H_IDLE || lnk.busy;
         flag_q <= lnk.table_status_flag;
         done_q <= lnk.done;
      end
   end

   assign lnk.op_start     = start_q;
   assign lnk.op_kind      = op_q;
   assign lnk.tbl_len      = stack_q;
   assign lnk.tbl_base     = acc_q;
   assign lnk.operand_addr = opnd_q;
   assign lnk.scan_end     = scan_end_q;
   assign lnk.mem_rdata    = rdata_q;
   assign user_mem_rdata   = urdata_q;
   assign seq_busy         = busy_q;
   assign table_flag       = flag_q;
   assign op_done          = done_q;

endmodule : tpmu_sequencer

/* File: test/tpmu_properties.sv */
// Concurrent checks on the link between the sequencer end and the engine end.
`timescale 1ns/1ps
module tpmu_properties
   import tpmu_pkg::*;
(
   input wire logic              clock,
   input wire logic              srst,
   input wire logic              op_start,
   input wire tpmu_op_e          op_kind,
   input wire logic [LEN_W-1:0]  tbl_len,
   input wire logic [WORD_W-1:0] tbl_base,
   input wire logic [WORD_W-1:0] operand_addr,
   input wire logic              scan_end,
   input wire logic              busy,
   input wire logic              done,
   input wire logic              table_status_flag,
   input wire logic              mem_en,
   input wire logic              mem_we,
   input wire logic [WORD_W-1:0] mem_addr,
   input wire logic [WORD_W-1:0] mem_wdata,
   input wire logic [WORD_W-1:0] mem_rdata
);
   // ----------------------------------------------------------------
   // Pointer capture
   // ----------------------------------------------------------------
   logic              rd_base_q;
   logic [WORD_W-1:0] ptr_q;
   logic [WORD_W-1:0] len_w;
   logic              wr_any;
   logic              wr_base;
   assign len_w   = {LEN_PAD, tbl_len};
   assign wr_any  = mem_en && mem_we;
   assign wr_base = wr_any && (mem_addr == tbl_base);
   always_ff @(posedge clock) begin
      rd_base_q <= !srst && mem_en && !mem_we && (mem_addr == tbl_base);
   end
   // The pointer word as read at the start of the operation.
   always_ff @(posedge clock) begin
      if (rd_base_q) begin
         ptr_q <= mem_rdata;
      end
   end
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   chk_done_pulse: assert property (done |=> !done)
      else $error("done held longer than one cycle");
   chk_start_answer: assert property (op_start && !busy |-> ##[3:800] done)
      else $error("taken operation never completed");
   chk_ptr_read: assert property (op_start && !busy |=> mem_en && !mem_we && mem_addr == tbl_base)
      else $error("first access is not a read of the table start word");
   chk_mem_busy: assert property (mem_en |-> busy)
      else $error("memory access outside an operation");
   chk_write_range: assert property (wr_any && mem_addr != operand_addr |->
      mem_addr >= tbl_base && mem_addr - tbl_base <= len_w + PTR_STEP)
      else $error("write outside the table");
   chk_dec_step: assert property (wr_base && op_kind != SOURCE_TO_TABLE_OP |-> mem_wdata == ptr_q - PTR_STEP)
      else $error("pointer not reduced by one");
   chk_stt_step: assert property (wr_base && op_kind == SOURCE_TO_TABLE_OP |->
      mem_wdata == ((ptr_q == PTR_ZERO || ptr_q == len_w) ? FIRST_ENTRY : ptr_q + PTR_STEP))
      else $error("pointer advanced wrongly");
   chk_stt_range: assert property (busy && op_kind == SOURCE_TO_TABLE_OP && ptr_q > len_w |-> !wr_any)
      else $error("data moved with pointer out of range");
   chk_bottom_flag: assert property (done && op_kind == REMOVE_FROM_BOTTOM_OP |->
      table_status_flag == (ptr_q <= PTR_STEP))
      else $error("bottom removal flag wrong");
   chk_table_flag: assert property (done && op_kind == REMOVE_FROM_TABLE_OP |->
      table_status_flag == (ptr_q <= PTR_STEP || ptr_q > len_w))
      else $error("table removal flag wrong");
   chk_flag_clear: assert property (scan_end ##1 !done |-> !table_status_flag)
      else $error("flag survived the end of scan");
   chk_flag_hold: assert property (!done && !$past(scan_end) |-> $stable(table_status_flag))
      else $error("flag changed without cause");
endmodule : tpmu_properties

/* File: test/table_pointer_move_unit_bench.sv */
// Bench joining the sequencer end and the engine end, checked against a word model.
`timescale 1ns/1ps
module table_pointer_move_unit_bench;
   import tpmu_pkg::*;
   logic              clock, srst, contact, one_shot, scan_req, u_we;
   logic              seq_busy, table_flag, op_done, eng_flag, eng_busy;
   tpmu_op_e          op_sel;
   logic [LEN_W-1:0]  t_len;
   logic [WORD_W-1:0] t_base, opa, u_addr, u_wdata, u_rdata;
   int                miscompares, total_checks, i, extra;
   int                mdl [int];
   tpmu_if lnk ();
   tpmu_engine i_tpmu_engine (.clock(clock), .srst(srst), .lnk(lnk.dev), .flag_out(eng_flag), .busy_out(eng_busy));
   tpmu_sequencer i_tpmu_sequencer (.clock(clock), .srst(srst), .lnk(lnk.seq), .enabling_input_contact(contact),
      .rising_one_shot(one_shot), .op_sel(op_sel), .table_len(t_len), .table_base(t_base), .operand_addr(opa),
      .scan_end_req(scan_req), .user_mem_we(u_we), .user_mem_addr(u_addr), .user_mem_wdata(u_wdata),
      .user_mem_rdata(u_rdata), .seq_busy(seq_busy), .table_flag(table_flag), .op_done(op_done));
   tpmu_properties i_tpmu_properties (.clock(clock), .srst(srst), .op_start(lnk.op_start), .op_kind(lnk.op_kind),
      .tbl_len(lnk.tbl_len), .tbl_base(lnk.tbl_base), .operand_addr(lnk.operand_addr), .scan_end(lnk.scan_end),
      .busy(lnk.busy), .done(lnk.done), .table_status_flag(lnk.table_status_flag), .mem_en(lnk.mem_en),
      .mem_we(lnk.mem_we), .mem_addr(lnk.mem_addr), .mem_wdata(lnk.mem_wdata), .mem_rdata(lnk.mem_rdata));
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic tick;
      @(posedge clock);
      #1;
   endtask : tick
   task automatic chk(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input int a, input int d);
      u_we = 1'b1;
      u_addr = WORD_W'(a);
      u_wdata = WORD_W'(d);
      mdl[a] = d;
      tick();
      u_we = 1'b0;
      tick();
   endtask : wr
   task automatic cmp(input int a);
      u_addr = WORD_W'(a);
      tick();
      tick();
      chk(u_rdata, WORD_W'(mdl[a]));
   endtask : cmp
   task automatic conclude;
      $display("checks %0d, mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : conclude
   // Runs one scan with the contact closed; hold leaves it closed afterwards.
   task automatic exec_op(input tpmu_op_e op, input int base, input int len, input int src, input bit hold);
      int   p, idx, k, n;
      logic ef;
      logic seen;
      p = mdl[base];
      ef = 1'b1;
      case (op)
         REMOVE_FROM_BOTTOM_OP: if (p != 0) begin
            mdl[src] = mdl[base+p];
            mdl[base] = p - 1;
            ef = (p == 1);
         end
         SOURCE_TO_TABLE_OP: if (p > len) begin
            ef = 1'b0;
         end else begin
            idx = (p == 0 || p == len) ? 1 : p + 1;
            mdl[base+idx] = mdl[src];
            mdl[base] = idx;
            ef = (idx == len);
         end
         default: if (p != 0 && p <= len) begin
            mdl[src] = mdl[base+1];
            for (k = 1; k < p; k++) mdl[base+k] = mdl[base+k+1];
            mdl[base] = p - 1;
            ef = (p == 1);
         end
      endcase
      op_sel = op;
      t_len = LEN_W'(len);
      t_base = WORD_W'(base);
      opa = WORD_W'(src);
      contact = 1'b1;
      seen = 1'b0;
      for (n = 0; n < 900 && !seen; n++) begin
         tick();
         seen = (op_done === 1'b1);
      end
      chk(WORD_W'(seen), 16'h0001);
      chk(WORD_W'(table_flag), WORD_W'(ef));
      chk(WORD_W'(eng_flag), WORD_W'(ef));
      chk(WORD_W'(eng_busy), 16'h0000);
      chk(WORD_W'(seq_busy), 16'h0001);
      for (n = 0; n < 20; n++) begin
         tick();
         if (op_done === 1'b1) seen = 1'b0;
      end
      chk(WORD_W'(seen), 16'h0001);
      chk(WORD_W'(seq_busy), 16'h0000);
      contact = hold;
      scan_req = 1'b1;
      tick();
      scan_req = 1'b0;
      repeat (5) tick();
      chk(WORD_W'(table_flag), 16'h0000);
      for (k = 0; k <= len + 1; k++) if (mdl.exists(base+k) && mdl[base+k] >= 0) cmp(base + k);
      cmp(src);
   endtask : exec_op
   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   initial begin
      #200000;
      miscompares++;
      $display("unexpected at %0t: watchdog expired", $time);
      conclude();
   end
   initial begin
      srst = 1'b1;
      {contact, one_shot, scan_req, u_we} = 4'h0;
      op_sel = REMOVE_FROM_BOTTOM_OP;
      {t_len, t_base, opa, u_addr, u_wdata} = '0;
      miscompares = 0;
      total_checks = 0;
      void'($urandom(32'h5263a58d));
      repeat (12) tick();
      srst = 1'b0;
      wr(16'h0100, 3);
      for (i = 1; i <= 6; i++) wr(16'h0100 + i, int'($urandom_range(16'hffff)));
      repeat (4) exec_op(REMOVE_FROM_BOTTOM_OP, 16'h0100, 6, 16'h0140, 1'b0);
      wr(16'h0200, 0);
      repeat (5) begin
         wr(16'h0240, int'($urandom_range(16'hffff)));
         exec_op(SOURCE_TO_TABLE_OP, 16'h0200, 3, 16'h0240, 1'b0);
      end
      wr(16'h0200, 5);
      exec_op(SOURCE_TO_TABLE_OP, 16'h0200, 3, 16'h0240, 1'b0);
      wr(16'h0300, 0);
      wr(16'h0340, int'($urandom_range(16'hffff)));
      exec_op(SOURCE_TO_TABLE_OP, 16'h0300, 0, 16'h0340, 1'b0);
      wr(16'h0280, 4);
      for (i = 1; i <= 6; i++) wr(16'h0280 + i, int'($urandom_range(16'hffff)));
      repeat (5) exec_op(REMOVE_FROM_TABLE_OP, 16'h0280, 6, 16'h02c0, 1'b0);
      wr(16'h0280, 7);
      exec_op(REMOVE_FROM_TABLE_OP, 16'h0280, 6, 16'h02c0, 1'b0);
      one_shot = 1'b1;
      wr(16'h0280, 1);
      exec_op(REMOVE_FROM_TABLE_OP, 16'h0280, 6, 16'h02c0, 1'b1);
      extra = 0;
      repeat (2) begin
         repeat (40) begin
            tick();
            if (op_done === 1'b1) extra++;
         end
         contact = 1'b0;
         scan_req = 1'b1;
         tick();
         scan_req = 1'b0;
      end
      chk(WORD_W'(extra), 16'h0000);
      conclude();
   end
endmodule : table_pointer_move_unit_bench
